// ===== hdl/plo_pkg.sv
// Package of the programmable logic output block: offsets, fields, resets, timing.
// Assumes a 40 MHz APB clock and 32-bit aligned register words.
package plo_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [11:0] ADDR_LOGIC_CFG   = 12'h000;
   localparam logic [11:0] ADDR_STATUS_IN   = 12'h004;
   localparam logic [11:0] ADDR_ROUTE       = 12'h008;
   localparam logic [11:0] ADDR_SETTLE      = 12'h00C;
   localparam logic [11:0] ADDR_FM_GAIN     = 12'h010;
   localparam logic [11:0] ADDR_AM_GAIN     = 12'h014;
   localparam logic [11:0] ADDR_AM_BIAS     = 12'h018;
   localparam logic [11:0] ADDR_RESULT      = 12'h01C;
   localparam logic [11:0] ADDR_STEP        = 12'h020;
   localparam logic [11:0] ADDR_METER_IN    = 12'h024;
   localparam logic [11:0] ADDR_METER_OUT   = 12'h028;
   localparam logic [11:0] ADDR_LOGIC_OP    = 12'h02C;

   // ==========================================================
   // Operand codes: 0 is no-function, high codes reserved for the block's own results
   localparam int          SEL_W            = 5;
   localparam int          NUM_STATUS       = 24;
   localparam logic [4:0]  SEL_NONE         = 5'h00;
   localparam logic [4:0]  SEL_COMB1        = 5'h19;
   localparam logic [4:0]  SEL_COMB2        = 5'h1A;
   localparam logic [4:0]  SEL_COMB3        = 5'h1B;
   localparam logic [4:0]  SEL_OPTION       = 5'h1C;
   localparam logic [4:0]  SEL_RESET        = 5'h00;

   // Operator codes
   localparam logic [1:0]  OP_AND           = 2'h0;
   localparam logic [1:0]  OP_OR            = 2'h1;
   localparam logic [1:0]  OP_XOR           = 2'h2;

   // Route codes per terminal: 0 off, 1..3 combined result unit
   localparam logic [1:0]  ROUTE_OFF        = 2'h0;

   // Selector pair of one unit in LOGIC_CFG (10 bits per unit); operators 2 bits each in LOGIC_OP
   localparam int          UNIT_W           = 10;
   localparam int          FLD_SEL_A        = 0;
   localparam int          FLD_SEL_B        = 5;
   localparam int          OP_W             = 2;

   // ==========================================================
   // Settling and scaling
   localparam logic [7:0]  SETTLE_MAX       = 8'hC8;
   localparam int          SETTLE_UNIT_MS   = 10;
   localparam int          CLK_KHZ          = 40000;
   localparam int          SETTLE_UNIT_CYC  = SETTLE_UNIT_MS * CLK_KHZ;
   localparam logic [7:0]  GAIN_MIN         = 8'h32;
   localparam logic [7:0]  GAIN_MAX         = 8'hC8;
   localparam logic [7:0]  GAIN_RESET       = 8'h64;
   localparam logic [6:0]  BIAS_MAX         = 7'h64;
   localparam logic [6:0]  BIAS_RESET       = 7'h00;
   localparam logic [15:0] METER_FULL       = 16'hFFFF;
   localparam int          STEP_W           = 4;

   typedef struct packed {
      logic [1:0]       op;
      logic [SEL_W-1:0] sel_b;
      logic [SEL_W-1:0] sel_a;
   } plo_unit_cfg_t;

   typedef struct packed {
      logic [15:0] fm;
      logic [15:0] am;
   } plo_meter_t;

endpackage

// ===== hdl/plo_combiner.sv
// One logic-output unit: two operand selectors and an AND/OR/XOR operator.
// Assumes a registered configuration and status vector from the same clock.
`timescale 1ns/1ps
module plo_combiner (
   input  wire logic                   [plo_pkg::NUM_STATUS:1] status,
   input  wire plo_pkg::plo_unit_cfg_t                         cfg,
   output logic                                                result
);
   logic a;
   logic b;

   // ==========================================================
   // Operand pick and combine
   always_comb begin
      a = 1'b0;
      b = 1'b0;
      if (cfg.sel_a != plo_pkg::SEL_NONE && cfg.sel_a <= plo_pkg::SEL_W'(plo_pkg::NUM_STATUS)) begin
         a = status[cfg.sel_a];
      end
      if (cfg.sel_b != plo_pkg::SEL_NONE && cfg.sel_b <= plo_pkg::SEL_W'(plo_pkg::NUM_STATUS)) begin
         b = status[cfg.sel_b];
      end
      unique case (cfg.op)
         plo_pkg::OP_OR:  result = a | b;
         plo_pkg::OP_XOR: result = a ^ b;
         default:         result = a & b;
      endcase
   end

endmodule

// ===== hdl/plo_meter_scale.sv
// Meter scaling: value times gain percent, plus bias percent of full scale, saturated.
// Assumes gain and bias already limited to their legal ranges.
`timescale 1ns/1ps
module plo_meter_scale (
   input  wire logic [15:0] value_in,
   input  wire logic [7:0]  gain_pct,
   input  wire logic [6:0]  bias_pct,
   output logic      [15:0] value_out
);
   logic [23:0] prod;
   logic [23:0] scaled;
   logic [23:0] bias;
   logic [24:0] sum;

   always_comb begin
      prod      = 24'(value_in) * 24'(gain_pct);
      scaled    = prod / 24'd100;
      bias      = (24'(plo_pkg::METER_FULL) * 24'(bias_pct)) / 24'd100;
      sum       = 25'(scaled) + 25'(bias);
      value_out = (sum > 25'(plo_pkg::METER_FULL)) ? plo_pkg::METER_FULL : sum[15:0];
   end

endmodule

// ===== hdl/plo_top.sv
// Programmable logic output block with APB register access.
// Assumes status, step and meter inputs are async pins; one 40 MHz clock.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module plo_top #(
   parameter int UNIT_CYCLES = plo_pkg::SETTLE_UNIT_CYC
) (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [11:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [plo_pkg::NUM_STATUS:1]  status_in,
   input  wire logic [plo_pkg::STEP_W-1:0]    step_in,
   input  wire plo_pkg::plo_meter_t           meter_in,
   output logic                               out_terminal1,
   output logic                               out_terminal2,
   output logic                               out_relay,
   output logic      [plo_pkg::STEP_W-1:0]    step_fixed,
   output logic      [15:0]                   frequency_meter_output,
   output logic      [15:0]                   current_meter_output
);

   if (UNIT_CYCLES < 1) begin : g_bad_unit
      $error("UNIT_CYCLES must be at least 1");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT} plo_settle_st_t;

   typedef struct packed {
      logic [plo_pkg::NUM_STATUS:1] st_s1;
      logic [plo_pkg::NUM_STATUS:1] st_s2;
      logic [plo_pkg::STEP_W-1:0]   stp_s1;
      logic [plo_pkg::STEP_W-1:0]   stp_s2;
      logic [plo_pkg::STEP_W-1:0]   stp_last;
      plo_pkg::plo_meter_t          mtr_s1;
      plo_pkg::plo_meter_t          mtr_s2;
      plo_pkg::plo_unit_cfg_t [2:0] cfg;
      logic [1:0]                   route_t1;
      logic [1:0]                   route_t2;
      logic [1:0]                   route_rl;
      logic [7:0]                   settle;
      logic [7:0]                   fm_gain;
      logic [7:0]                   am_gain;
      logic [6:0]                   am_bias;
      plo_settle_st_t               sst;
      logic [31:0]                  cyc_cnt;
      logic [7:0]                   unit_cnt;
      logic [plo_pkg::STEP_W-1:0]   step_fix;
      logic                         t1;
      logic                         t2;
      logic                         rl;
      logic [15:0]                  fm_out;
      logic [15:0]                  am_out;
      logic [31:0]                  rdata;
      logic                         ready;
      logic                         slverr;
   } plo_state_t;

   plo_state_t state_reg;
   plo_state_t state_next;
   logic [2:0]  comb_res;
   logic [15:0] fm_scaled;
   logic [15:0] am_scaled;

   // ==========================================================
   // Combiner units
   for (genvar u = 0; u < 3; u++) begin : g_unit
      plo_combiner u_comb (
         .status (state_reg.st_s2),
         .cfg    (state_reg.cfg[u]),
         .result (comb_res[u])
      );
   end

   plo_meter_scale u_fm (
      .value_in  (state_reg.mtr_s2.fm),
      .gain_pct  (state_reg.fm_gain),
      .bias_pct  (plo_pkg::BIAS_RESET),
      .value_out (fm_scaled)
   );

   plo_meter_scale u_am (
      .value_in  (state_reg.mtr_s2.am),
      .gain_pct  (state_reg.am_gain),
      .bias_pct  (state_reg.am_bias),
      .value_out (am_scaled)
   );

   function automatic logic sel_ok(input logic [plo_pkg::SEL_W-1:0] s);
      sel_ok = (s != plo_pkg::SEL_NONE) && (s != plo_pkg::SEL_COMB1) &&
               (s != plo_pkg::SEL_COMB2) && (s != plo_pkg::SEL_COMB3) &&
               (s != plo_pkg::SEL_OPTION) &&
               (s <= plo_pkg::SEL_W'(plo_pkg::NUM_STATUS));
   endfunction

   function automatic logic route_pick(input logic [1:0] r, input logic [2:0] res);
      route_pick = (r == plo_pkg::ROUTE_OFF) ? 1'b0 : res[r - 2'd1];
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      state_next        = state_reg;
      state_next.st_s1  = status_in;
      state_next.st_s2  = state_reg.st_s1;
      state_next.stp_s1 = step_in;
      state_next.stp_s2 = state_reg.stp_s1;
      state_next.mtr_s1 = meter_in;
      state_next.mtr_s2 = state_reg.mtr_s1;
      state_next.ready  = 1'b0;
      state_next.slverr = 1'b0;

      // APB slave: one wait state, answer in access phase second cycle
      if (psel && penable && !state_reg.ready) begin
         state_next.ready = 1'b1;
         state_next.rdata = 32'h0000_0000;
         if (pwrite) begin
            unique case (paddr)
               plo_pkg::ADDR_LOGIC_CFG: begin
                  for (int u = 0; u < 3; u++) begin
                     if (sel_ok(pwdata[u*plo_pkg::UNIT_W+plo_pkg::FLD_SEL_A +: plo_pkg::SEL_W]))
                        state_next.cfg[u].sel_a =
                           pwdata[u*plo_pkg::UNIT_W+plo_pkg::FLD_SEL_A +: plo_pkg::SEL_W];
                     if (sel_ok(pwdata[u*plo_pkg::UNIT_W+plo_pkg::FLD_SEL_B +: plo_pkg::SEL_W]))
                        state_next.cfg[u].sel_b =
                           pwdata[u*plo_pkg::UNIT_W+plo_pkg::FLD_SEL_B +: plo_pkg::SEL_W];
                  end
               end
               plo_pkg::ADDR_LOGIC_OP: begin
                  for (int u = 0; u < 3; u++) begin
                     // Code 3 is no operator: the old one is kept
                     if (pwdata[u*plo_pkg::OP_W +: plo_pkg::OP_W] <= plo_pkg::OP_XOR)
                        state_next.cfg[u].op =
                           pwdata[u*plo_pkg::OP_W +: plo_pkg::OP_W];
                  end
               end
               plo_pkg::ADDR_ROUTE: begin
                  state_next.route_t1 = pwdata[1:0];
                  state_next.route_t2 = pwdata[3:2];
                  state_next.route_rl = pwdata[5:4];
               end
               plo_pkg::ADDR_SETTLE: begin
                  if (pwdata[7:0] <= plo_pkg::SETTLE_MAX && pwdata[31:8] == 24'h00_0000)
                     state_next.settle = pwdata[7:0];
                  else
                     state_next.slverr = 1'b1;
               end
               plo_pkg::ADDR_FM_GAIN: begin
                  if (pwdata[7:0] >= plo_pkg::GAIN_MIN && pwdata[7:0] <= plo_pkg::GAIN_MAX &&
                      pwdata[31:8] == 24'h00_0000)
                     state_next.fm_gain = pwdata[7:0];
                  else
                     state_next.slverr = 1'b1;
               end
               plo_pkg::ADDR_AM_GAIN: begin
                  if (pwdata[7:0] >= plo_pkg::GAIN_MIN && pwdata[7:0] <= plo_pkg::GAIN_MAX &&
                      pwdata[31:8] == 24'h00_0000)
                     state_next.am_gain = pwdata[7:0];
                  else
                     state_next.slverr = 1'b1;
               end
               plo_pkg::ADDR_AM_BIAS: begin
                  if (pwdata[6:0] <= plo_pkg::BIAS_MAX && pwdata[31:7] == 25'h000_0000)
                     state_next.am_bias = pwdata[6:0];
                  else
                     state_next.slverr = 1'b1;
               end
               default: state_next.slverr = 1'b1;
            endcase
         end else begin
            unique case (paddr)
               plo_pkg::ADDR_LOGIC_CFG:
                  for (int u = 0; u < 3; u++)
                     state_next.rdata[u*plo_pkg::UNIT_W +: plo_pkg::UNIT_W] =
                        {state_reg.cfg[u].sel_b, state_reg.cfg[u].sel_a};
               plo_pkg::ADDR_LOGIC_OP:
                  state_next.rdata = {26'h000_0000, state_reg.cfg[2].op, state_reg.cfg[1].op,
                                      state_reg.cfg[0].op};
               plo_pkg::ADDR_STATUS_IN:
                  state_next.rdata = {{(32-plo_pkg::NUM_STATUS){1'b0}}, state_reg.st_s2};
               plo_pkg::ADDR_ROUTE:
                  state_next.rdata = {26'h000_0000, state_reg.route_rl, state_reg.route_t2,
                                      state_reg.route_t1};
               plo_pkg::ADDR_SETTLE:  state_next.rdata = {24'h00_0000, state_reg.settle};
               plo_pkg::ADDR_FM_GAIN: state_next.rdata = {24'h00_0000, state_reg.fm_gain};
               plo_pkg::ADDR_AM_GAIN: state_next.rdata = {24'h00_0000, state_reg.am_gain};
               plo_pkg::ADDR_AM_BIAS: state_next.rdata = {25'h000_0000, state_reg.am_bias};
               plo_pkg::ADDR_RESULT:
                  state_next.rdata = {26'h000_0000, state_reg.rl, state_reg.t2, state_reg.t1,
                                      comb_res};
               plo_pkg::ADDR_STEP:
                  state_next.rdata = {{(32-plo_pkg::STEP_W){1'b0}}, state_reg.step_fix};
               plo_pkg::ADDR_METER_IN:  state_next.rdata = state_reg.mtr_s2;
               plo_pkg::ADDR_METER_OUT: state_next.rdata = {state_reg.fm_out, state_reg.am_out};
               default: state_next.slverr = 1'b1;
            endcase
         end
      end

      // Terminal routing
      state_next.t1 = route_pick(state_reg.route_t1, comb_res);
      state_next.t2 = route_pick(state_reg.route_t2, comb_res);
      state_next.rl = route_pick(state_reg.route_rl, comb_res);
      state_next.fm_out = fm_scaled;
      state_next.am_out = am_scaled;

      // Step settling timer
      unique case (state_reg.sst)
         ST_IDLE: begin
            if (state_reg.stp_s2 != state_reg.stp_last) begin
               state_next.stp_last = state_reg.stp_s2;
               if (state_reg.settle == 8'h00) begin
                  state_next.step_fix = state_reg.stp_s2;
               end else begin
                  state_next.sst      = ST_WAIT;
                  state_next.cyc_cnt  = 32'h0000_0000;
                  state_next.unit_cnt = 8'h00;
               end
            end
         end
         ST_WAIT: begin
            if (state_reg.stp_s2 != state_reg.stp_last) begin
               state_next.stp_last = state_reg.stp_s2;   // Restart the wait on further change
               state_next.cyc_cnt  = 32'h0000_0000;
               state_next.unit_cnt = 8'h00;
            end else if (state_reg.cyc_cnt == 32'(UNIT_CYCLES - 1)) begin
               state_next.cyc_cnt  = 32'h0000_0000;
               state_next.unit_cnt = state_reg.unit_cnt + 8'h01;
               if (state_reg.unit_cnt + 8'h01 >= state_reg.settle) begin
                  state_next.step_fix = state_reg.stp_last;
                  state_next.sst      = ST_IDLE;
               end
            end else begin
               state_next.cyc_cnt = state_reg.cyc_cnt + 32'h0000_0001;
            end
         end
         default: state_next.sst = ST_IDLE;
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg          <= '0;
         for (int u = 0; u < 3; u++) begin
            state_reg.cfg[u].sel_a <= plo_pkg::SEL_RESET;
            state_reg.cfg[u].sel_b <= plo_pkg::SEL_RESET;
            state_reg.cfg[u].op    <= plo_pkg::OP_AND;
         end
         state_reg.sst      <= ST_IDLE;
         state_reg.fm_gain  <= plo_pkg::GAIN_RESET;
         state_reg.am_gain  <= plo_pkg::GAIN_RESET;
         state_reg.am_bias  <= plo_pkg::BIAS_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata                 = state_reg.rdata;
   assign pready                 = state_reg.ready;
   assign pslverr                = state_reg.slverr;
   assign out_terminal1          = state_reg.t1;
   assign out_terminal2          = state_reg.t2;
   assign out_relay              = state_reg.rl;
   assign step_fixed             = state_reg.step_fix;
   assign frequency_meter_output = state_reg.fm_out;
   assign current_meter_output   = state_reg.am_out;

endmodule

// ===== testbench/plo_assertions.sv
// Checker for plo_top: APB handshake, step settling and output relations.
// Assumes only the ports of plo_top; bound to it at the foot of this file.
`timescale 1ns/1ps
module plo_assertions (
   input wire logic                         pclk,
   input wire logic                         presetn,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [11:0]                  paddr,
   input wire logic [31:0]                  pwdata,
   input wire logic [31:0]                  prdata,
   input wire logic                         pready,
   input wire logic                         pslverr,
   input wire logic [plo_pkg::NUM_STATUS:1] status_in,
   input wire logic [plo_pkg::STEP_W-1:0]   step_in,
   input wire plo_pkg::plo_meter_t          meter_in,
   input wire logic                         out_terminal1,
   input wire logic                         out_terminal2,
   input wire logic                         out_relay,
   input wire logic [plo_pkg::STEP_W-1:0]   step_fixed,
   input wire logic [15:0]                  frequency_meter_output,
   input wire logic [15:0]                  current_meter_output
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ========
   // Bus handshake
   property p_ready_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready not one cycle after take");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_err_ready;
      pslverr |-> pready && psel && penable;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("pslverr outside an access end");
   property p_unmapped;
      psel && penable && !pready && paddr > 12'h02C |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   // ========
   // Outputs against their causes
   property p_quiet;
      (status_in == '0)[*5] |-> !(out_terminal1 || out_terminal2 || out_relay);
   endproperty
   a_quiet: assert property (p_quiet) else $error("result high with all operands low");
   property p_fm_zero;
      (meter_in.fm == 16'h0)[*6] |-> frequency_meter_output == 16'h0;
   endproperty
   a_fm_zero: assert property (p_fm_zero) else $error("scaled zero meter not zero");
   property p_step_src;
      $changed(step_fixed) |-> step_fixed == $past(step_in, 2) || step_fixed == $past(step_in, 4);
   endproperty
   a_step_src: assert property (p_step_src) else $error("fixed step not from input");
   property p_out_stable;
      ($stable(status_in) && !(psel && pwrite))[*6]
         |-> $stable({out_terminal1, out_terminal2, out_relay});
   endproperty
   a_out_stable: assert property (p_out_stable) else $error("outputs moved without cause");
   c_refused: cover property (pready && pslverr);
   c_step: cover property ($changed(step_fixed));
   c_relay: cover property ($rose(out_relay));
endmodule

bind plo_top plo_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .status_in(status_in), .step_in(step_in),
   .meter_in(meter_in), .out_terminal1(out_terminal1), .out_terminal2(out_terminal2),
   .out_relay(out_relay), .step_fixed(step_fixed),
   .frequency_meter_output(frequency_meter_output),
   .current_meter_output(current_meter_output));

// ===== testbench/plo_field_model.sv
// Far-side model: status, step and meter sources feeding the block's pins.
// Assumes the bench hands it requested levels; it drives them one edge later.
`timescale 1ns/1ps
module plo_field_model (
   input  wire logic                pclk,
   input  wire logic [24:1]         status_req,
   input  wire logic [3:0]          step_req,
   input  wire plo_pkg::plo_meter_t meter_req,
   output logic      [24:1]         status_in,
   output logic      [3:0]          step_in,
   output plo_pkg::plo_meter_t      meter_in
);
   always @(posedge pclk) begin
      status_in <= status_req;
      step_in <= step_req;
      meter_in <= meter_req;
   end
endmodule

// ===== testbench/plo_top_tb.sv
// Self-checking bench of plo_top over APB, with the field model on its pins.
// Assumes a short settling unit of 4 cycles set through UNIT_CYCLES.
`timescale 1ns/1ps
module plo_top_tb;
   typedef struct packed {logic rd; logic err; logic [31:0] data;} plo_exp_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, out_terminal1, out_terminal2, out_relay;
   logic [3:0] step_fixed, sp_req = '0, step_in;
   logic [15:0] fm_out, am_out;
   logic [24:1] st_req = '0, status_in;
   plo_pkg::plo_meter_t mt_req = '0, meter_in;
   int error_cnt = 0, check_count = 0, seed = 11871;
   plo_exp_t exp_q[$];
   plo_exp_t cur;
   logic [29:0] cfg, ncfg;
   logic [5:0] ops, nops;
   logic [4:0] sa[3], sb[3];
   logic [1:0] op[3];
   logic [2:0] res, term;
   logic [5:0] rt;

   plo_top #(.UNIT_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .status_in(status_in), .step_in(step_in),
      .meter_in(meter_in), .out_terminal1(out_terminal1), .out_terminal2(out_terminal2),
      .out_relay(out_relay), .step_fixed(step_fixed), .frequency_meter_output(fm_out),
      .current_meter_output(am_out));
   plo_field_model i_field (.pclk(pclk), .status_req(st_req), .step_req(sp_req),
      .meter_req(mt_req), .status_in(status_in), .step_in(step_in), .meter_in(meter_in));

   initial begin
      forever #12.5 pclk = ~pclk;
   end
   // ========
   // Checking and closing
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
      check_count++;
      if (seen !== x) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, x, seen);
      end
   endtask
   task automatic test_done;
      if (error_cnt == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   function automatic logic comb(input logic [1:0] o, input logic a, input logic b);
      case (o)
         2'h0: return a & b;
         2'h1: return a | b;
         default: return a ^ b;
      endcase
   endfunction
   // ========
   // APB master; psel stays up so a following setup may come at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic e, input logic [31:0] x);
      int n;
      exp_q.push_back('{rd: !w, err: e, data: x});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      penable <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         test_done();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0);
      apb(1'b1, a, d, e, 32'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e = 1'b0);
      apb(1'b0, a, 32'h0, e, x);
   endtask
   task automatic idle(input int n);
      psel <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask
   always @(negedge pclk) begin
      if (pready === 1'b1) begin
         cur = exp_q.pop_front();
         chk("pslverr", 32'(pslverr), 32'(cur.err));
         if (cur.rd)
            chk("prdata", prdata, cur.data);
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      test_done();
   end
   // ========
   // Main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(plo_pkg::ADDR_LOGIC_CFG, 32'h0);
      rd(plo_pkg::ADDR_ROUTE, 32'h0);
      rd(plo_pkg::ADDR_SETTLE, 32'h0);
      rd(plo_pkg::ADDR_FM_GAIN, 32'h64);
      rd(plo_pkg::ADDR_AM_GAIN, 32'h64);
      rd(plo_pkg::ADDR_AM_BIAS, 32'h0);
      rd(plo_pkg::ADDR_LOGIC_OP, 32'h0);
      rd(12'h030, 32'h0, 1'b1);
      wr(plo_pkg::ADDR_FM_GAIN, 32'h31, 1'b1);
      wr(plo_pkg::ADDR_AM_GAIN, 32'hC9, 1'b1);
      wr(plo_pkg::ADDR_AM_BIAS, 32'h65, 1'b1);
      wr(plo_pkg::ADDR_SETTLE, 32'hC9, 1'b1);
      rd(plo_pkg::ADDR_FM_GAIN, 32'h64);
      for (int t = 0; t < 12; t++) begin
         for (int u = 0; u < 3; u++) begin
            sa[u] = 5'(1 + {$random(seed)} % 24);
            sb[u] = 5'(1 + {$random(seed)} % 24);
            op[u] = 2'((u + t) % 3);
            cfg[10*u +: 10] = {sb[u], sa[u]};
            ops[2*u +: 2] = op[u];
         end
         rt = {2'((t + 2) % 3 + 1), 2'((t + 1) % 3 + 1), 2'(t % 3 + 1)};
         wr(plo_pkg::ADDR_LOGIC_CFG, {2'h0, cfg});
         wr(plo_pkg::ADDR_LOGIC_OP, {26'h0, ops});
         wr(plo_pkg::ADDR_ROUTE, {26'h0, rt});
         st_req <= 24'($random(seed));
         idle(7);
         for (int u = 0; u < 3; u++)
            res[u] = comb(op[u], st_req[sa[u]], st_req[sb[u]]);
         for (int k = 0; k < 3; k++)
            term[k] = res[rt[2*k +: 2] - 2'h1];
         chk("terminals", 32'({out_relay, out_terminal2, out_terminal1}), 32'(term));
         rd(plo_pkg::ADDR_RESULT, 32'({term, res}));
         rd(plo_pkg::ADDR_STATUS_IN, {8'h0, st_req});
      end
      ncfg = cfg;
      ncfg[4:0] = 5'h19;
      ncfg[9:5] = 5'h00;
      ncfg[14:10] = 5'h1C;
      ncfg[29:25] = 5'h1F;
      ncfg[24:20] = 5'h18;
      cfg[24:20] = 5'h18;
      nops = ops;
      nops[3:2] = 2'h3;
      wr(plo_pkg::ADDR_LOGIC_CFG, {2'h0, ncfg});
      rd(plo_pkg::ADDR_LOGIC_CFG, {2'h0, cfg});
      wr(plo_pkg::ADDR_LOGIC_OP, {26'h0, nops});
      rd(plo_pkg::ADDR_LOGIC_OP, {26'h0, ops});
      wr(plo_pkg::ADDR_SETTLE, 32'hC8);
      rd(plo_pkg::ADDR_SETTLE, 32'hC8);
      wr(plo_pkg::ADDR_SETTLE, 32'h3);
      idle(1);
      sp_req <= 4'h5;
      idle(8);
      chk("step held", 32'(step_fixed), 32'h0);
      idle(14);
      chk("step fixed", 32'(step_fixed), 32'h5);
      sp_req <= 4'h6;
      idle(8);
      sp_req <= 4'h7;
      idle(9);
      chk("step restart", 32'(step_fixed), 32'h5);
      idle(14);
      rd(plo_pkg::ADDR_STEP, 32'h7);
      wr(plo_pkg::ADDR_SETTLE, 32'h0);
      idle(1);
      sp_req <= 4'h9;
      idle(5);
      chk("step no wait", 32'(step_fixed), 32'h9);
      mt_req <= '{fm: 16'h03E8, am: 16'h07D0};
      wr(plo_pkg::ADDR_FM_GAIN, 32'h96);
      wr(plo_pkg::ADDR_AM_GAIN, 32'h32);
      wr(plo_pkg::ADDR_AM_BIAS, 32'h14);
      idle(8);
      chk("fm scaled", 32'(fm_out), 32'h05DC);
      chk("am scaled", 32'(am_out), 32'h371B);
      rd(plo_pkg::ADDR_METER_OUT, 32'h05DC_371B);
      rd(plo_pkg::ADDR_METER_IN, 32'h03E8_07D0);
      mt_req <= '{fm: 16'hFFFF, am: 16'hFFFF};
      wr(plo_pkg::ADDR_FM_GAIN, 32'hC8);
      wr(plo_pkg::ADDR_AM_GAIN, 32'hC8);
      wr(plo_pkg::ADDR_AM_BIAS, 32'h64);
      idle(8);
      chk("meters full", {fm_out, am_out}, 32'hFFFF_FFFF);
      test_done();
   end
endmodule
